// file: msf_consts.svh
`ifndef MSF_CONSTS_SVH
`define MSF_CONSTS_SVH

// ****************************************
// register map (index = byte address / 4)
// ****************************************
`define MSF_FIRST_STATUS_IDX 8'h41
`define MSF_SECOND_STATUS_IDX 8'h42
`define MSF_IRQ_STATUS_IDX 8'h60
`define MSF_IRQ_MASK_IDX 8'h61
`define MSF_PIN_CONFIG_IDX 8'h62
`define MSF_STATUS_RESET 8'h00
`define MSF_IRQ_RESET 2'h0
`define MSF_MASK_RESET 2'h0
`define MSF_PIN_CONFIG_RESET 2'h0

// ****************************************
// field positions
// ****************************************
`define MSF_S1_SUMMARY_BIT 7
`define MSF_S2_CHAIN_BIT 1
`define MSF_S2_SPEED4_BIT 5
`define MSF_S2_DIODE1_BIT 6
`define MSF_S2_DIODE2_BIT 7
`define MSF_CFG_PIN22_BIT 0
`define MSF_CFG_PIN14_BIT 1
`define MSF_IRQ_FIRST_BIT 0
`define MSF_IRQ_SECOND_BIT 1

`endif

// file: msf_pkg.sv
package msf_pkg;

	typedef struct packed {
		logic [3:0] volt_first;
		logic remote_one_temp;
		logic local_temp;
		logic remote_two_temp;
		logic volt_12;
		logic [3:0] fan_stall;
		logic overtemp_timer_over;
		logic diode_one;
		logic diode_two;
		logic chained_third;
	} msf_cause_type;

	typedef struct packed {
		logic first_fan_drive;
		logic second_fan_drive;
		logic third_fan_drive;
	} msf_drive_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} msf_apb_req_type;

endpackage : msf_pkg

// file: msf_status.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "msf_consts.svh"

module msf_status
	import msf_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire msf_apb_req_type apb_i,
	output logic pready_o,
	output logic pslverr_o,
	output logic [31:0] prdata_o,
	input wire msf_cause_type cause_i,
	input wire msf_drive_type drive_i,
	output logic irq_o
);

	// ****************************************
	// bus decode
	// ****************************************
	function automatic logic hit(input logic [31:0] addr,
		input logic [7:0] idx);
		hit = (addr == {22'h000000, idx, 2'h0});
	endfunction : hit

	logic [7:0] first_status;
	logic [7:0] second_status;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic [1:0] pin_config;
	logic [7:0] next_first_status;
	logic [7:0] next_second_status;
	logic [1:0] next_irq_status;
	logic [1:0] next_irq_mask;
	logic [1:0] next_pin_config;
	logic [31:0] next_prdata;
	logic [7:0] cause_first;
	logic [7:0] cause_second;
	logic access;
	logic wr;
	logic rd;
	logic mapped;

	// zero wait states: every access completes in its first access cycle
	assign access = apb_i.psel & apb_i.penable;
	assign wr = access & apb_i.pwrite;
	assign rd = access & ~apb_i.pwrite;
	assign pready_o = 1'b1;
	assign mapped = hit(apb_i.paddr, `MSF_FIRST_STATUS_IDX)
		| hit(apb_i.paddr, `MSF_SECOND_STATUS_IDX)
		| hit(apb_i.paddr, `MSF_IRQ_STATUS_IDX)
		| hit(apb_i.paddr, `MSF_IRQ_MASK_IDX)
		| hit(apb_i.paddr, `MSF_PIN_CONFIG_IDX);
	assign pslverr_o = access & ~mapped;

	// ****************************************
	// live causes
	// ****************************************
	always_comb begin
		cause_first = 8'h00;
		cause_second = 8'h00;
		cause_first[3:0] = cause_i.volt_first;
		if (pin_config[`MSF_CFG_PIN22_BIT]) begin
			cause_first[0] = cause_i.overtemp_timer_over;
		end
		cause_first[4] = cause_i.remote_one_temp;
		cause_first[5] = cause_i.local_temp;
		cause_first[6] = cause_i.remote_two_temp;
		cause_second[0] = cause_i.volt_12;
		// fan flags ignored while the drive is off: a stopped fan is no fault
		cause_second[2] = cause_i.fan_stall[0]
			& drive_i.first_fan_drive;
		cause_second[3] = cause_i.fan_stall[1]
			& drive_i.second_fan_drive;
		cause_second[4] = cause_i.fan_stall[2]
			& drive_i.third_fan_drive;
		if (pin_config[`MSF_CFG_PIN14_BIT]) begin
			cause_second[`MSF_S2_SPEED4_BIT] =
				cause_i.overtemp_timer_over;
		end else begin
			cause_second[`MSF_S2_SPEED4_BIT] = cause_i.fan_stall[3]
				& drive_i.third_fan_drive;
		end
		cause_second[`MSF_S2_DIODE1_BIT] = cause_i.diode_one;
		cause_second[`MSF_S2_DIODE2_BIT] = cause_i.diode_two;
	end

	// ****************************************
	// status, interrupt and config next state
	// ****************************************
	always_comb begin
		next_first_status = first_status;
		next_second_status = second_status;
		// read clears only flags whose cause is gone; set wins
		if (rd && hit(apb_i.paddr, `MSF_FIRST_STATUS_IDX)) begin
			next_first_status = first_status & cause_first;
		end
		if (rd && hit(apb_i.paddr, `MSF_SECOND_STATUS_IDX)) begin
			next_second_status = second_status & cause_second;
		end
		// status writes fall through: flags have no write path
		next_second_status = next_second_status | cause_second;
		// chain bit follows the third register live, never latched
		next_second_status[`MSF_S2_CHAIN_BIT] =
			cause_i.chained_third;
		next_first_status = next_first_status | cause_first;
		next_first_status[`MSF_S1_SUMMARY_BIT] =
			|next_second_status;
		next_irq_status = irq_status;
		next_irq_mask = irq_mask;
		next_pin_config = pin_config;
		if (wr && hit(apb_i.paddr, `MSF_IRQ_STATUS_IDX)) begin
			next_irq_status = irq_status & ~apb_i.pwdata[1:0];
		end
		if (wr && hit(apb_i.paddr, `MSF_IRQ_MASK_IDX)) begin
			next_irq_mask = apb_i.pwdata[1:0];
		end
		if (wr && hit(apb_i.paddr, `MSF_PIN_CONFIG_IDX)) begin
			next_pin_config = apb_i.pwdata[1:0];
		end
		// new latch events set sticky bits; set beats a same-cycle clear
		if (|(cause_first & ~first_status)) begin
			next_irq_status[`MSF_IRQ_FIRST_BIT] = 1'b1;
		end
		if (|(cause_second & ~second_status)) begin
			next_irq_status[`MSF_IRQ_SECOND_BIT] = 1'b1;
		end
	end

	always_comb begin
		next_prdata = 32'h00000000;
		if (rd) begin
			if (hit(apb_i.paddr, `MSF_FIRST_STATUS_IDX)) begin
				next_prdata[7:0] = first_status;
			end
			if (hit(apb_i.paddr, `MSF_SECOND_STATUS_IDX)) begin
				next_prdata[7:0] = second_status;
			end
			if (hit(apb_i.paddr, `MSF_IRQ_STATUS_IDX)) begin
				next_prdata[1:0] = irq_status;
			end
			if (hit(apb_i.paddr, `MSF_IRQ_MASK_IDX)) begin
				next_prdata[1:0] = irq_mask;
			end
			if (hit(apb_i.paddr, `MSF_PIN_CONFIG_IDX)) begin
				next_prdata[1:0] = pin_config;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			first_status <= `MSF_STATUS_RESET;
			second_status <= `MSF_STATUS_RESET;
			irq_status <= `MSF_IRQ_RESET;
			irq_mask <= `MSF_MASK_RESET;
			pin_config <= `MSF_PIN_CONFIG_RESET;
			irq_o <= 1'b0;
		end else begin
			first_status <= next_first_status;
			second_status <= next_second_status;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			pin_config <= next_pin_config;
			irq_o <= |(next_irq_status & next_irq_mask);
		end
	end

	// read data is combinational from the flops so it is valid in
	// the single access cycle; reads see pre-clear values
	assign prdata_o = next_prdata;

endmodule : msf_status

// file: msf_status_asserts.sv
`timescale 1ns/1ps
module msf_status_asserts
	import msf_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire msf_apb_req_type apb_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [31:0] prdata_o,
	input wire msf_cause_type cause_i,
	input wire msf_drive_type drive_i,
	input wire logic irq_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	wire logic acc = apb_i.psel & apb_i.penable & !apb_i.pwrite;
	wire logic rd1 = acc & (apb_i.paddr == 32'h104);
	wire logic rd2 = acc & (apb_i.paddr == 32'h108);
	wire logic bad = apb_i.psel & apb_i.penable &
		!(apb_i.paddr inside {32'h104, 32'h108, 32'h180, 32'h184, 32'h188});
	// ****
	// gone cause, two quiet cycles, then a second read
	// ****
	sequence clr_rd;
		rd1 && !cause_i.volt_first[1] ##1 !cause_i.volt_first[1] [*2];
	endsequence
	chk_volt_latch: assert property (rd1 && $past(rstn_i) |->
		($past(cause_i.volt_first[3:1]) & ~prdata_o[3:1]) == 3'h0)
		else $error("voltage flag lost");
	chk_temp_latch: assert property (rd1 && $past(rstn_i) |->
		($past({cause_i.remote_two_temp, cause_i.local_temp,
		cause_i.remote_one_temp}) & ~prdata_o[6:4]) == 3'h0)
		else $error("temperature flag lost");
	chk_summary_set: assert property (rd1 &&
		$past(rstn_i && cause_i.volt_12) |-> prdata_o[7])
		else $error("summary bit low");
	chk_fan_latch: assert property (rd2 && $past(rstn_i &&
		cause_i.fan_stall[0] && drive_i.first_fan_drive) |-> prdata_o[2])
		else $error("fan flag lost");
	chk_diode_latch: assert property (rd2 && $past(rstn_i) |->
		($past({cause_i.diode_two, cause_i.diode_one}) & ~prdata_o[7:6]) == 2'h0)
		else $error("diode flag lost");
	chk_chain_live: assert property (rd2 && $past(rstn_i) |->
		prdata_o[1] == $past(cause_i.chained_third))
		else $error("chained bit wrong");
	chk_clear_gone: assert property (clr_rd ##1 rd1 |-> !prdata_o[1])
		else $error("flag kept after cause gone");
	chk_unmapped_err: assert property (bad |-> pslverr_o && prdata_o == 32'h0)
		else $error("unmapped access not refused");
endmodule : msf_status_asserts

bind msf_status msf_status_asserts u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i),
	.apb_i(apb_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.prdata_o(prdata_o), .cause_i(cause_i), .drive_i(drive_i), .irq_o(irq_o));

// file: test_monitor_status_flags.sv
`timescale 1ns/1ps
module test_monitor_status_flags
	import msf_pkg::*;
;
	logic mclk_i = 0, rstn_i = 0, pready_o, pslverr_o, irq_o;
	logic [31:0] prdata_o, r = 32'h0001674C;
	logic [31:0] tbl [6] = '{32'h104, 32'h108, 32'h180, 32'h184, 32'h188, 32'h1FC};
	msf_apb_req_type req = '0;
	msf_cause_type cause = '0;
	msf_drive_type drv = '0;
	logic [7:0] s1, s2, c1, c2, n2;
	logic [1:0] ist, msk, cfg;
	int err_count = 0, total_checks = 0;
	msf_status DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .apb_i(req),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
		.cause_i(cause), .drive_i(drv), .irq_o(irq_o));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function logic acc(input logic w, input logic [31:0] a);
		return req.psel & req.penable & (req.pwrite == w) & (req.paddr == a);
	endfunction : acc
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task automatic chk(input string n, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic op(input logic w, input logic [31:0] a, d);
		logic [31:0] e, rdat;
		logic rdy, serr;
		@(posedge mclk_i);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk_i);
		req.penable <= 1'b1;
		// mid-cycle values equal what the closing edge samples, no race
		do begin
			@(negedge mclk_i);
			rdy = pready_o;
			rdat = prdata_o;
			serr = pslverr_o;
			e = a == 32'h104 ? s1 : a == 32'h108 ? s2 : a == 32'h180 ? ist :
				a == 32'h184 ? msk : a == 32'h188 ? cfg : 0;
			@(posedge mclk_i);
		end while (rdy !== 1'b1);
		chk("pready", rdy, 1'b1);
		if (!w)
			chk("prdata", rdat, e);
		chk("pslverr", serr, a == 32'h1FC);
		req <= '0;
	endtask : op
	// ****
	// reference model, sees the same pre-edge inputs as the design
	// ****
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{s1, s2, ist, msk, cfg} <= '0;
		end else begin
			c1 = {1'b0, cause.remote_two_temp, cause.local_temp,
				cause.remote_one_temp, cause.volt_first[3:1],
				cfg[0] ? cause.overtemp_timer_over : cause.volt_first[0]};
			c2 = {cause.diode_two, cause.diode_one, cfg[1] ?
				cause.overtemp_timer_over : cause.fan_stall[3] & drv.third_fan_drive,
				cause.fan_stall[2:0] & {drv.third_fan_drive,
				drv.second_fan_drive, drv.first_fan_drive},
				cause.chained_third, cause.volt_12};
			n2 = (acc(0, 32'h108) ? s2 & c2 : s2) | c2;
			n2[1] = c2[1];
			s2 <= n2;
			s1 <= {|n2, 7'((acc(0, 32'h104) ? s1 & c1 : s1) | c1)};
			ist <= (acc(1, 32'h180) ? ist & ~req.pwdata[1:0] : ist) |
				{|(c2 & ~s2 & 8'hFD), |(c1 & ~s1)};
			if (acc(1, 32'h184))
				msk <= req.pwdata[1:0];
			if (acc(1, 32'h188))
				cfg <= req.pwdata[1:0];
		end
	end
	initial begin
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		#300000;
		err_count++;
		print_verdict;
	end
	initial begin
		repeat (12) @(posedge mclk_i);
		rstn_i <= 1'b1;
		op(0, 32'h104, 0);
		op(0, 32'h108, 0);
		// sparse causes so reads can also clear
		repeat (150) begin
			r = lfsr(r);
			cause <= msf_cause_type'(r[15:0] & r[31:16]);
			drv <= msf_drive_type'(r[18:16]);
			op(r[3], tbl[r[7:5] % 6], r);
		end
		for (int m = 0; m < 4; m += 3) begin
			cause <= '0;
			op(0, 32'h104, 0);
			op(0, 32'h104, 0);
			op(0, 32'h108, 0);
			op(1, 32'h184, m);
			op(1, 32'h180, 3);
			cause <= msf_cause_type'(16'h0100);
			op(0, 32'h104, 0);
			cause <= '0;
			repeat (3) @(posedge mclk_i);
			@(negedge mclk_i);
			chk("irq", irq_o, |(ist & msk));
			op(1, 32'h180, 3);
			repeat (3) @(posedge mclk_i);
			@(negedge mclk_i);
			chk("irq", irq_o, 1'b0);
		end
		print_verdict;
	end
endmodule : test_monitor_status_flags
